// >>> design/pci_port_ctrl.sv
// Overview of operation
// RULE1: Legacy high-cap detect off at reset, optional.
// RULE2: Class has five values; class 0 as 3.
// RULE3: Classify after detect in semi/auto; manual on command.
// RULE4: Probe voltage for probe time, store class.
// RULE5: Auto mode loads cut and limit from class.
// RULE6: No classing: strap low, shutdown, enable clear.
// RULE7: Ping-pong class 4: mark, pause, classify again.
// RULE8: Second cycle sets high power status bit.
// RULE9: Host sets ping-pong enable bit.
// RULE10: First class 0 to 3 skips second cycle.
// RULE11: Auto powers any class except 4 then lower.
// RULE12: Status class holds most recent pulse result.
// RULE13: Cut and limit writable while powered.
// RULE14: Default larger sense resistor; option selects smaller.
// RULE15: Power-on ramps gate at inrush limit, timer runs.
// RULE16: Still over inrush at expiry: off, start fault.
// RULE17: Semi high power needs detect good, else fault.
// RULE18: Auto thresholds per class table, limit 425 else.
// RULE19: Mark pause is a configurable cycle count.
// RULE20: Start timer parameter, inrush comparator input sampled.
//
// The register offsets and the APB slave port are this design's own decisions.
module pci_port_ctrl
  import pci_pkg::*;
#(
  parameter int CLASS_CYC = CLASS_PROBE_CYC,
  parameter int START_TIME_CYC = START_CYC,
  parameter int BACKOFF_TIME_CYC = BACKOFF_CYC,
  parameter int DETECT_TIME_CYC = DETECT_CYC,
  parameter int MARK_CYC = MARK_PAUSE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic autoPin,
  input wire logic sigValid,
  input wire logic sigHighCap,
  input wire logic [2:0] classMeas,
  input wire logic inrushOver,
  output logic detectForce,
  output logic classForce,
  output logic markForce,
  output logic gateOn,
  output logic inrushRegulate,
  output logic senseSmall,
  output logic [11:0] overload_cut_threshold,
  output logic [11:0] hard_current_limit
);
  initial begin
    if (CLASS_CYC < 1 || START_TIME_CYC < 1 || BACKOFF_TIME_CYC < 1 ||
        DETECT_TIME_CYC < 1 || MARK_CYC < 1) begin
      $error("pci_port_ctrl: timing counts must be at least one");
    end
  end

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_DETECT = 8'h02, ST_CLASS1 = 8'h04,
    ST_MARK = 8'h08, ST_CLASS2 = 8'h10, ST_INRUSH = 8'h20,
    ST_POWER = 8'h40, ST_BACKOFF = 8'h80
  } pci_state_type;

  pci_state_type state_reg;
  pci_tmr_if tbus ();
  logic tmrLoad_reg;
  logic [31:0] tmrCount_reg;
  logic [6:0] pinQ;
  logic autoQ;
  logic sigValidQ;
  logic sigHighCapQ;
  logic [2:0] classQ;
  logic inrushOverQ;

  pci_sync #(.W(7)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({autoPin, sigValid, sigHighCap, classMeas, inrushOver}),
    .q(pinQ)
  );
  assign {autoQ, sigValidQ, sigHighCapQ, classQ, inrushOverQ} = pinQ;

  pci_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(tbus)
  );
  assign tbus.load = tmrLoad_reg;
  assign tbus.count = tmrCount_reg;

  // Control registers
  pci_mode_type mode_reg;
  logic detEn_reg, classEn_reg, legacyEn_reg, pingPongEn_reg;
  logic hiPwrEn_reg, rSmall_reg, autoStrap_reg, strapDone_reg;
  logic [2:0] strapCnt_reg;
  logic detCmd_reg, clsCmd_reg, onCmd_reg, offCmd_reg;
  logic [2:0] class_reg;
  pci_det_type det_reg;
  logic second_reg, startFault_reg;
  logic [11:0] cut_reg, lim_reg;
  logic firstWas4_reg;

  logic wrEn, rdEn;
  assign wrEn = psel && penable && pwrite && pready;
  assign rdEn = psel && penable && !pready;

  logic autoMode, manualMode, semiMode, classAllowed, tmrDone;
  assign autoMode = (mode_reg == MODE_AUTO) && autoStrap_reg;
  assign semiMode = (mode_reg == MODE_SEMI) ||
                    ((mode_reg == MODE_AUTO) && !autoStrap_reg);
  assign manualMode = (mode_reg == MODE_MANUAL);
  assign classAllowed = classEn_reg && (mode_reg != MODE_SHUT); // RULE6
  assign tmrDone = tbus.done;

  // Detect-good outcome with optional legacy capacitance
  logic detGoodNow;
  assign detGoodNow = sigValidQ || (legacyEn_reg && sigHighCapQ); // RULE1

  // Power-on request outcome
  logic onTake, onRefuse;
  assign onTake = onCmd_reg && !autoMode && (mode_reg != MODE_SHUT) &&
                  (state_reg == ST_IDLE || state_reg == ST_BACKOFF) &&
                  !(semiMode && hiPwrEn_reg && det_reg != DET_GOOD); // RULE17
  assign onRefuse = onCmd_reg && semiMode && hiPwrEn_reg &&
                    det_reg != DET_GOOD &&
                    (state_reg == ST_IDLE || state_reg == ST_BACKOFF); // RULE17

  logic detTake, clsTake, offTake;
  assign detTake = state_reg == ST_IDLE && manualMode && detCmd_reg;
  assign clsTake = state_reg == ST_IDLE && manualMode && clsCmd_reg &&
                   !detCmd_reg;
  assign offTake = offCmd_reg;

  // Strap capture after reset release; strap cannot feed async reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strapCnt_reg <= 3'h0;
      strapDone_reg <= 1'b0;
      autoStrap_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      strapCnt_reg <= strapCnt_reg + 3'h1;
      if (strapCnt_reg == 3'(STRAP_CYC)) begin
        strapDone_reg <= 1'b1;
        autoStrap_reg <= autoQ;
      end
    end
  end

  // CTRL register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_SHUT;
      detEn_reg <= 1'b0;
      classEn_reg <= 1'b0;
      legacyEn_reg <= 1'b0; // RULE1
      pingPongEn_reg <= 1'b0;
      hiPwrEn_reg <= 1'b0;
      rSmall_reg <= 1'b0; // RULE14
    end else if (!strapDone_reg) begin
      if (strapCnt_reg == 3'(STRAP_CYC) && autoQ) begin
        mode_reg <= MODE_AUTO;
        detEn_reg <= 1'b1;
        classEn_reg <= 1'b1;
      end
    end else if (wrEn && paddr == CTRL_OFS) begin
      mode_reg <= pci_mode_type'(pwdata[MODE_LSB +: 2]);
      detEn_reg <= pwdata[DETEN_BIT];
      classEn_reg <= pwdata[CLSEN_BIT];
      legacyEn_reg <= pwdata[LEGACY_BIT];
      pingPongEn_reg <= pwdata[PINGPONG_BIT]; // RULE9
      hiPwrEn_reg <= pwdata[HIPWR_BIT];
      rSmall_reg <= pwdata[RSMALL_BIT]; // RULE14
    end
  end

  // Command flags; a new command beats its own consumption
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      detCmd_reg <= 1'b0;
      clsCmd_reg <= 1'b0;
      onCmd_reg <= 1'b0;
      offCmd_reg <= 1'b0;
    end else begin
      if (wrEn && paddr == CMD_OFS && pwdata[CMD_DET_BIT]) begin
        detCmd_reg <= 1'b1;
      end else if (detTake || mode_reg != MODE_MANUAL) begin
        detCmd_reg <= 1'b0;
      end
      if (wrEn && paddr == CMD_OFS && pwdata[CMD_CLS_BIT]) begin
        clsCmd_reg <= 1'b1;
      end else if (clsTake || mode_reg != MODE_MANUAL) begin
        clsCmd_reg <= 1'b0;
      end
      if (wrEn && paddr == CMD_OFS && pwdata[CMD_ON_BIT]) begin
        onCmd_reg <= 1'b1;
      end else if (onTake || onRefuse || autoMode ||
                   state_reg == ST_INRUSH || state_reg == ST_POWER) begin
        onCmd_reg <= 1'b0;
      end
      if (wrEn && paddr == CMD_OFS && pwdata[CMD_OFF_BIT]) begin
        offCmd_reg <= 1'b1;
      end else if (offTake) begin
        offCmd_reg <= 1'b0;
      end
    end
  end

  // Port sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      tmrLoad_reg <= 1'b0;
      tmrCount_reg <= 32'h0000_0000;
      firstWas4_reg <= 1'b0;
    end else begin
      tmrLoad_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (onTake) begin
            state_reg <= ST_INRUSH; // RULE15
            tmrLoad_reg <= 1'b1;
            tmrCount_reg <= 32'(START_TIME_CYC); // RULE20
          end else if (strapDone_reg && (detTake ||
                       (!manualMode && mode_reg != MODE_SHUT && detEn_reg))) begin
            state_reg <= ST_DETECT;
            tmrLoad_reg <= 1'b1;
            tmrCount_reg <= 32'(DETECT_TIME_CYC);
          end else if (clsTake && classAllowed) begin
            state_reg <= ST_CLASS1; // RULE3
            tmrLoad_reg <= 1'b1;
            tmrCount_reg <= 32'(CLASS_CYC);
          end
        end
        ST_DETECT: begin
          if (mode_reg == MODE_SHUT) begin
            state_reg <= ST_IDLE;
          end else if (tmrDone) begin
            tmrLoad_reg <= 1'b1;
            if (manualMode) begin
              state_reg <= ST_IDLE;
            end else if (detGoodNow && classAllowed) begin
              state_reg <= ST_CLASS1; // RULE3
              tmrCount_reg <= 32'(CLASS_CYC); // RULE4
            end else if (detGoodNow && autoMode) begin
              state_reg <= ST_INRUSH;
              tmrCount_reg <= 32'(START_TIME_CYC);
            end else begin
              state_reg <= ST_BACKOFF;
              tmrCount_reg <= 32'(BACKOFF_TIME_CYC);
            end
          end
        end
        ST_CLASS1: begin
          if (mode_reg == MODE_SHUT) begin
            state_reg <= ST_IDLE;
          end else if (tmrDone) begin
            tmrLoad_reg <= 1'b1;
            firstWas4_reg <= classQ == CLASS4;
            if (pingPongEn_reg && classQ == CLASS4) begin
              state_reg <= ST_MARK; // RULE7
              tmrCount_reg <= 32'(MARK_CYC); // RULE19
            end else if (manualMode) begin
              state_reg <= ST_IDLE; // RULE10
            end else if (autoMode) begin
              state_reg <= ST_INRUSH;
              tmrCount_reg <= 32'(START_TIME_CYC);
            end else begin
              state_reg <= ST_BACKOFF;
              tmrCount_reg <= 32'(BACKOFF_TIME_CYC);
            end
          end
        end
        ST_MARK: begin
          if (mode_reg == MODE_SHUT) begin
            state_reg <= ST_IDLE;
          end else if (tmrDone) begin
            state_reg <= ST_CLASS2; // RULE7
            tmrLoad_reg <= 1'b1;
            tmrCount_reg <= 32'(CLASS_CYC);
          end
        end
        ST_CLASS2: begin
          if (mode_reg == MODE_SHUT) begin
            state_reg <= ST_IDLE;
          end else if (tmrDone) begin
            tmrLoad_reg <= 1'b1;
            if (manualMode) begin
              state_reg <= ST_IDLE;
            end else if (autoMode && classQ == CLASS4) begin
              state_reg <= ST_INRUSH;
              tmrCount_reg <= 32'(START_TIME_CYC);
            end else begin
              // Semi mode, or invalid pair in auto mode: no power, detect again
              state_reg <= ST_BACKOFF; // RULE11
              tmrCount_reg <= 32'(BACKOFF_TIME_CYC);
            end
          end
        end
        ST_INRUSH: begin
          if (offTake || mode_reg == MODE_SHUT) begin
            state_reg <= ST_IDLE;
          end else if (tmrDone) begin
            if (inrushOverQ) begin
              state_reg <= ST_BACKOFF; // RULE16
              tmrLoad_reg <= 1'b1;
              tmrCount_reg <= 32'(BACKOFF_TIME_CYC);
            end else begin
              state_reg <= ST_POWER;
            end
          end
        end
        ST_POWER: begin
          if (offTake || mode_reg == MODE_SHUT) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_BACKOFF: begin
          if (onTake) begin
            state_reg <= ST_INRUSH;
            tmrLoad_reg <= 1'b1;
            tmrCount_reg <= 32'(START_TIME_CYC);
          end else if (tmrDone || mode_reg == MODE_SHUT || manualMode) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Port status: detect and class results
  logic classEnd;
  assign classEnd = tmrDone && mode_reg != MODE_SHUT &&
                    (state_reg == ST_CLASS1 || state_reg == ST_CLASS2);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      class_reg <= 3'h0;
      det_reg <= DET_UNKNOWN;
    end else begin
      if (classEnd) begin
        class_reg <= classQ; // RULE12
      end
      if (state_reg == ST_DETECT && tmrDone && mode_reg != MODE_SHUT) begin
        det_reg <= detGoodNow ? DET_GOOD : DET_BAD;
      end
    end
  end

  // Sticky status: hardware set wins over write-one-to-clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      second_reg <= 1'b0;
      startFault_reg <= 1'b0;
    end else begin
      if (state_reg == ST_MARK && tmrDone && mode_reg != MODE_SHUT) begin
        second_reg <= 1'b1; // RULE8
      end else if (wrEn && paddr == HPSTAT_OFS && pwdata[HP_SECOND_BIT]) begin
        second_reg <= 1'b0;
      end
      if ((state_reg == ST_INRUSH && tmrDone && inrushOverQ &&
           !offTake && mode_reg != MODE_SHUT) || onRefuse) begin
        startFault_reg <= 1'b1; // RULE16 RULE17
      end else if (wrEn && paddr == HPSTAT_OFS && pwdata[HP_SFAULT_BIT]) begin
        startFault_reg <= 1'b0;
      end
    end
  end

  // Thresholds; class 0 handled as class 3
  logic [11:0] autoCut;
  always_comb begin
    case (classQ)
      3'h1: autoCut = CUT_CLS1_MA;
      3'h2: autoCut = CUT_CLS2_MA;
      3'h4: autoCut = CUT_CLS4_MA;
      default: autoCut = CUT_CLS3_MA; // RULE2
    endcase
  end

  logic goingOff;
  assign goingOff = (state_reg == ST_POWER || state_reg == ST_INRUSH) &&
                    (offTake || mode_reg == MODE_SHUT);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cut_reg <= CUT_CLS3_MA;
      lim_reg <= LIM_TYPE1_MA;
    end else if (wrEn && paddr == CUT_OFS) begin
      cut_reg <= pwdata[11:0]; // RULE13
    end else if (wrEn && paddr == LIM_OFS) begin
      lim_reg <= pwdata[11:0]; // RULE13
    end else if (autoMode && classEnd) begin
      cut_reg <= autoCut; // RULE5 RULE18
      lim_reg <= (classQ == CLASS4) ? LIM_CLS4_MA : LIM_TYPE1_MA; // RULE18
    end else if (goingOff) begin
      lim_reg <= LIM_TYPE1_MA;
    end
  end

  // Analog drive outputs, all registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      detectForce <= 1'b0;
      classForce <= 1'b0;
      markForce <= 1'b0;
      gateOn <= 1'b0;
      inrushRegulate <= 1'b0;
      senseSmall <= 1'b0;
      overload_cut_threshold <= CUT_CLS3_MA;
      hard_current_limit <= LIM_TYPE1_MA;
    end else begin
      detectForce <= state_reg == ST_DETECT;
      classForce <= state_reg == ST_CLASS1 || state_reg == ST_CLASS2; // RULE4
      markForce <= state_reg == ST_MARK; // RULE7
      gateOn <= state_reg == ST_INRUSH || state_reg == ST_POWER; // RULE15
      inrushRegulate <= state_reg == ST_INRUSH; // RULE15
      senseSmall <= rSmall_reg; // RULE14
      overload_cut_threshold <= cut_reg;
      // Inrush forces the Type 1 limit until start timer expiry
      hard_current_limit <= (state_reg == ST_INRUSH) ? LIM_TYPE1_MA : lim_reg;
    end
  end

  // APB slave: one wait state, reads latched when pready rises
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rdEn) begin
      pready <= 1'b1;
      pslverr <= paddr[1:0] != 2'h0 || paddr > LIM_OFS;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          CTRL_OFS: prdata <= {24'h00_0000, rSmall_reg, hiPwrEn_reg,
                               pingPongEn_reg, legacyEn_reg, classEn_reg,
                               detEn_reg, mode_reg};
          STAT_OFS: prdata <= {26'h000_0000, gateOn, det_reg, class_reg};
          HPSTAT_OFS: prdata <= {30'h0000_0000, startFault_reg, second_reg};
          CUT_OFS: prdata <= {20'h0_0000, cut_reg};
          LIM_OFS: prdata <= {20'h0_0000, lim_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : pci_port_ctrl

// >>> design/pci_pkg.sv
package pci_pkg;
  localparam int CLK_MHZ = 100;
  // Timing, in the unit of each name, then in cycles
  localparam int CLASS_PROBE_US = 12000;
  localparam int CLASS_PROBE_CYC = CLASS_PROBE_US * CLK_MHZ;
  localparam int BACKOFF_MS = 100;
  localparam int BACKOFF_CYC = BACKOFF_MS * 1000 * CLK_MHZ;
  localparam int START_US = 60000;
  localparam int START_CYC = START_US * CLK_MHZ;
  localparam int DETECT_US = 100000;
  localparam int DETECT_CYC = DETECT_US * CLK_MHZ;
  localparam int MARK_PAUSE_CYC = 1000;
  localparam int STRAP_CYC = 6;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] HPSTAT_OFS = 8'h0C;
  localparam logic [7:0] CUT_OFS = 8'h10;
  localparam logic [7:0] LIM_OFS = 8'h14;

  // CTRL fields
  localparam int MODE_LSB = 0;
  localparam int DETEN_BIT = 2;
  localparam int CLSEN_BIT = 3;
  localparam int LEGACY_BIT = 4;
  localparam int PINGPONG_BIT = 5;
  localparam int HIPWR_BIT = 6;
  localparam int RSMALL_BIT = 7;
  // CMD fields
  localparam int CMD_DET_BIT = 0;
  localparam int CMD_CLS_BIT = 1;
  localparam int CMD_ON_BIT = 2;
  localparam int CMD_OFF_BIT = 3;
  // STAT fields
  localparam int STAT_CLS_LSB = 0;
  localparam int STAT_DET_LSB = 3;
  localparam int STAT_PWR_BIT = 5;
  // HPSTAT fields
  localparam int HP_SECOND_BIT = 0;
  localparam int HP_SFAULT_BIT = 1;

  typedef enum logic [1:0] {
    MODE_SHUT = 2'h0, MODE_MANUAL = 2'h1, MODE_SEMI = 2'h2, MODE_AUTO = 2'h3
  } pci_mode_type;

  typedef enum logic [1:0] {
    DET_UNKNOWN = 2'h0, DET_GOOD = 2'h1, DET_BAD = 2'h2
  } pci_det_type;

  localparam logic [2:0] CLASS4 = 3'h4;

  // Thresholds in mA
  localparam logic [11:0] CUT_CLS1_MA = 12'd112;
  localparam logic [11:0] CUT_CLS2_MA = 12'd206;
  localparam logic [11:0] CUT_CLS3_MA = 12'd375;
  localparam logic [11:0] CUT_CLS4_MA = 12'd638;
  localparam logic [11:0] LIM_TYPE1_MA = 12'd425;
  localparam logic [11:0] LIM_CLS4_MA = 12'd850;
  localparam logic [11:0] INRUSH_MA = 12'd450;
endpackage : pci_pkg

// >>> design/pci_tmr_if.sv
interface pci_tmr_if;
  logic load;
  logic [31:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : pci_tmr_if

// >>> design/pci_timer.sv
module pci_timer (
  input wire logic ref_clk,
  input wire logic rst,
  pci_tmr_if.tmr bus
);
  logic [31:0] cnt_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0000_0000;
    end else if (bus.load) begin
      cnt_reg <= bus.count;
    end else if (cnt_reg != 32'h0000_0000) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
    end
  end

  assign bus.done = (cnt_reg == 32'h0000_0000) && !bus.load;
endmodule : pci_timer

// >>> design/pci_sync.sv
module pci_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        q[i] <= 1'b0;
      end else if (s2_reg[i] == s3_reg[i]) begin
        q[i] <= s3_reg[i];
      end
    end
  end
endmodule : pci_sync

// >>> dv/pci_port_ctrl_checker.sv
module pci_port_ctrl_checker #(
  parameter int CLASS_CYC = 20,
  parameter int START_TIME_CYC = 30,
  parameter int MARK_CYC = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic classForce,
  input wire logic markForce,
  input wire logic gateOn,
  input wire logic inrushRegulate,
  input wire logic [11:0] hard_current_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  int clsCnt, markCnt, inrCnt;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) clsCnt <= 0;
    else clsCnt <= classForce ? clsCnt + 1 : 0;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) markCnt <= 0;
    else markCnt <= markForce ? markCnt + 1 : 0;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) inrCnt <= 0;
    else inrCnt <= inrushRegulate ? inrCnt + 1 : 0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence markDone; $fell(markForce); endsequence
  sequence probeAgain; classForce ##1 classForce; endsequence
  a_force_excl: assert property (
    !(classForce && markForce)) else $error("Probe and mark overlap");
  a_mark_after: assert property (
    $rose(markForce) |-> $past(classForce)) else $error("Mark too early");
  a_pause_class: assert property (
    markDone |-> probeAgain) else $error("No second probe");
  a_mark_len: assert property (
    markDone |-> markCnt == MARK_CYC + 2) else $error("Mark length");
  a_class_len: assert property (
    $fell(classForce) |-> clsCnt == CLASS_CYC + 2) else $error("Probe time");
  a_inrush_lim: assert property (
    inrushRegulate |-> gateOn && hard_current_limit == 12'h1A9)
    else $error("Inrush limit wrong");
  a_inrush_len: assert property (
    $fell(inrushRegulate) |-> inrCnt == START_TIME_CYC + 2)
    else $error("Start timer length");
  a_gate_start: assert property (
    $rose(gateOn) |-> inrushRegulate) else $error("Gate without inrush");
endmodule : pci_port_ctrl_checker

bind pci_port_ctrl pci_port_ctrl_checker #(.CLASS_CYC(CLASS_CYC),
  .START_TIME_CYC(START_TIME_CYC), .MARK_CYC(MARK_CYC)) chk_inst (
  .ref_clk, .rst, .classForce, .markForce, .gateOn, .inrushRegulate,
  .hard_current_limit);

// >>> dv/pci_pd_model.sv
module pci_pd_model (
  input wire logic ref_clk,
  input wire logic detectForce,
  input wire logic classForce,
  input wire logic markForce,
  input wire logic gateOn,
  input wire logic good,
  input wire logic hiCap,
  input wire logic [2:0] cls1,
  input wire logic [2:0] cls2,
  input wire logic over,
  output logic sigValid,
  output logic sigHighCap,
  output logic [2:0] classMeas,
  output logic inrushOver
);
  timeunit 1ns;
  timeprecision 1ps;
  logic marked = 1'b0;
  always @(posedge ref_clk) begin
    if (detectForce) marked <= 1'b0;
    else if (markForce) marked <= 1'b1;
  end
  // Unprobed lines show the inverse so stale values never pass
  assign sigValid = detectForce ? good : ~good;
  assign sigHighCap = detectForce ? hiCap : ~hiCap;
  assign classMeas = classForce ? (marked ? cls2 : cls1) : ~cls1;
  assign inrushOver = gateOn & over;
endmodule : pci_pd_model

// >>> dv/pci_port_ctrl_bench.sv
module pci_port_ctrl_bench
  import pci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, psel, penable, pwrite, autoPin, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sigValid, sigHighCap, inrushOver, detectForce, classForce;
  logic markForce, gateOn, inrushRegulate, senseSmall, good, hiCap, over;
  logic lastErr, sawGate, sawMark, sawCls;
  logic [2:0] classMeas, cls1, cls2;
  logic [11:0] overload_cut_threshold, hard_current_limit;
  int fails, samplesChecked;
  pci_port_ctrl #(.CLASS_CYC(20), .START_TIME_CYC(30),
    .BACKOFF_TIME_CYC(40), .DETECT_TIME_CYC(20), .MARK_CYC(5))
    pci_port_ctrl_inst (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .autoPin, .sigValid, .sigHighCap,
    .classMeas, .inrushOver, .detectForce, .classForce, .markForce,
    .gateOn, .inrushRegulate, .senseSmall, .overload_cut_threshold,
    .hard_current_limit);
  pci_pd_model pci_pd_model_inst (.ref_clk, .detectForce, .classForce,
    .markForce, .gateOn, .good, .hiCap, .cls1, .cls2, .over, .sigValid,
    .sigHighCap, .classMeas, .inrushOver);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (gateOn === 1'b1) sawGate <= 1'b1;
    if (markForce === 1'b1) sawMark <= 1'b1;
    if (classForce === 1'b1) sawCls <= 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic wt(ref logic s, input logic v);
    for (int n = 0; s !== v; n++) begin
      if (n > 500) begin
        fails++;
        results();
      end
      @(posedge ref_clk);
    end
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    wt(pready, 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask : rd
  task automatic doReset(input logic ap);
    autoPin <= ap;
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    {sawGate, sawMark, sawCls} = 3'h0;
    // Strap settles seven edges after release
    repeat (12) @(posedge ref_clk);
  endtask : doReset
  function automatic logic [11:0] cutOf(input logic [2:0] c);
    case (c)
      3'h1: return 12'h070;
      3'h2: return 12'h0CE;
      CLASS4: return 12'h27E;
      default: return 12'h177;
    endcase
  endfunction : cutOf
  task automatic autoRun(input logic [2:0] c1, input logic [2:0] c2,
    input logic pp);
    logic two;
    logic [2:0] fin;
    logic [31:0] lim;
    two = pp && c1 == CLASS4;
    fin = two ? c2 : c1;
    lim = fin == CLASS4 ? 32'h352 : 32'h1A9;
    good <= 1'b1;
    cls1 <= c1;
    cls2 <= c2;
    over <= 1'b0;
    doReset(1'b1);
    if (pp) wr(CTRL_OFS, 32'h2F);
    wt(classForce, 1'b1);
    wt(classForce, 1'b0);
    if (two) begin
      wt(markForce, 1'b1);
      wt(classForce, 1'b1);
      wt(classForce, 1'b0);
    end
    rd(STAT_OFS, 32'h7, 32'(fin));
    rd(HPSTAT_OFS, 32'h1, 32'(two));
    check(32'(sawMark), 32'(two));
    if (two && c2 != CLASS4) begin
      wt(detectForce, 1'b1);
      check(32'(sawGate), 32'h0);
    end else begin
      wt(gateOn, 1'b1);
      check(32'(inrushRegulate), 32'h1);
      wt(inrushRegulate, 1'b0);
      repeat (2) @(posedge ref_clk);
      check(32'(gateOn), 32'h1);
      check(32'(overload_cut_threshold), 32'(cutOf(fin)));
      check(32'(hard_current_limit), lim);
    end
  endtask : autoRun
  task automatic startFault();
    good <= 1'b1;
    cls1 <= 3'h1;
    over <= 1'b1;
    doReset(1'b1);
    wt(inrushRegulate, 1'b1);
    wt(inrushRegulate, 1'b0);
    repeat (2) @(posedge ref_clk);
    check(32'(gateOn), 32'h0);
    rd(HPSTAT_OFS, 32'h2, 32'h2);
  endtask : startFault
  task automatic semiRun();
    logic [31:0] r;
    good <= 1'b0;
    over <= 1'b0;
    doReset(1'b0);
    check(32'(senseSmall), 32'h0);
    apb(1'b0, 8'h18, 32'h0, r);
    check(32'(lastErr), 32'h1);
    wr(CTRL_OFS, 32'h4E);
    wt(detectForce, 1'b1);
    wt(detectForce, 1'b0);
    rd(STAT_OFS, 32'h18, 32'h10);
    wr(CMD_OFS, 32'h4);
    rd(HPSTAT_OFS, 32'h2, 32'h2);
    check(32'(sawGate), 32'h0);
    wr(HPSTAT_OFS, 32'h3);
    // Legacy and small sense on, class off, before the next detect
    wr(CTRL_OFS, 32'hD6);
    wt(detectForce, 1'b1);
    wt(detectForce, 1'b0);
    rd(STAT_OFS, 32'h18, 32'h08);
    check(32'(senseSmall), 32'h1);
    repeat (10) @(posedge ref_clk);
    check(32'(sawCls), 32'h0);
    wr(CMD_OFS, 32'h4);
    wt(inrushRegulate, 1'b1);
    wt(inrushRegulate, 1'b0);
    check(32'(gateOn), 32'h1);
    wr(CUT_OFS, 32'h123);
    rd(CUT_OFS, 32'hFFF, 32'h123);
    check(32'(overload_cut_threshold), 32'h123);
  endtask : semiRun
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hiCap = 1'b1;
    fails = 0;
    samplesChecked = 0;
    for (int c = 0; c < 5; c++) autoRun(3'(c), 3'(c), 1'b0);
    autoRun(CLASS4, CLASS4, 1'b1);
    autoRun(CLASS4, 3'h2, 1'b1);
    autoRun(3'h2, 3'h2, 1'b1);
    startFault();
    semiRun();
    results();
  end
endmodule : pci_port_ctrl_bench
